// ==== design/rfef_pkg.sv ====
// Package: register map, field positions and timing for regulator event flags
`default_nettype none
package rfef_pkg;
  localparam int NUM_CH = 4;
  localparam logic [7:0] ADDR_TOP_EVENT = 8'h18;
  localparam logic [7:0] ADDR_PAIR_LOW = 8'h19;
  localparam logic [7:0] ADDR_PAIR_HIGH = 8'h1A;
  localparam logic [7:0] ADDR_THERMAL = 8'h1B;
  // Field positions within one channel nibble
  localparam int BIT_OVERCURRENT = 0;
  localparam int BIT_SHORT = 1;
  localparam int BIT_POWERGOOD = 2;
  localparam int NIBBLE = 4;
  // Thermal status and top-level event bit positions
  localparam int BIT_SHUTDOWN = 3;
  localparam int BIT_WARNING = 2;
  localparam int BIT_SUMMARY0 = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Timing: start-up short timeout
  localparam int CLK_HZ = 25000000;
  localparam int START_TIMEOUT_US = 1000;
  localparam int START_TIMEOUT_CYC = CLK_HZ / 1000000 * START_TIMEOUT_US;
  localparam int TIMER_W = 15;
endpackage
`default_nettype wire

// ==== design/rfef_channel.sv ====
// One converter channel: start-up timeout and three sticky event flags
`default_nettype none
module rfef_channel #(
  parameter int TIMEOUT_CYC = rfef_pkg::START_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic enabled,
  input wire logic above_short_level,
  input wire logic powergood_reached,
  input wire logic current_limit,
  input wire logic [2:0] clear,
  output logic [2:0] flags
);
  logic [rfef_pkg::TIMER_W-1:0] timer;
  logic [rfef_pkg::TIMER_W-1:0] next_timer;
  logic started;
  logic next_started;
  logic enabled_q;
  logic next_enabled_q;
  logic [2:0] event_now;
  logic [2:0] next_flags;
  logic timeout_hit;

  // Timer runs from enable until the output first crosses 0.35 V or the timeout fires
  always_comb begin
    next_enabled_q = enabled;
    next_timer = timer;
    next_started = started;
    timeout_hit = 1'b0;
    if (!enabled) begin
      next_timer = '0;
      next_started = 1'b0;
    end else if (enabled && !enabled_q) begin
      next_timer = '0;
      next_started = above_short_level;
    end else if (!started) begin
      if (above_short_level) begin
        next_started = 1'b1;
      end else if (timer == rfef_pkg::TIMER_W'(TIMEOUT_CYC - 1)) begin
        timeout_hit = 1'b1;
        next_started = 1'b1; // Report once, then watch for drops
      end else begin
        next_timer = timer + 1'b1;
      end
    end
  end

  // Set wins over clear so a coincident event is never lost
  always_comb begin
    event_now = '0;
    event_now[rfef_pkg::BIT_POWERGOOD] = powergood_reached;
    event_now[rfef_pkg::BIT_SHORT] = timeout_hit ||
      (enabled && started && !above_short_level);
    event_now[rfef_pkg::BIT_OVERCURRENT] = current_limit;
    next_flags = (flags & ~clear) | event_now;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      timer <= '0;
      started <= 1'b0;
      enabled_q <= 1'b0;
      flags <= '0;
    end else begin
      timer <= next_timer;
      started <= next_started;
      enabled_q <= next_enabled_q;
      flags <= next_flags;
    end
  end
endmodule
`default_nettype wire

// ==== design/rfef_top.sv ====
// Top: event flag registers, thermal status and register read/write port
`default_nettype none
//Contract
// - Each channel latches a sticky power-good event, bit 6 upper, bit 2 lower.
// - Each channel latches a short event when output drops below 0.35 V running.
// - Short event also latched if 0.35 V not reached within 1 ms of enable.
// - Each channel latches a current-limit event, bit 4 upper, bit 0 lower.
// - Flags stay set until the host writes one to that bit.
// - Channels 0-1 at 0x19, 2-3 at 0x1A; bits 7 and 3 read zero.
// - Thermal status bit 3 shows live shutdown comparator.
// - Thermal status bit 2 shows live warning; other bits read zero.
// - Summary bit per channel set while any of its flags pend.
// - Latched thermal events take live thermal status bits as source.
module rfef_top #(
  parameter int TIMEOUT_CYC = rfef_pkg::START_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] ch_enabled,
  input wire logic [3:0] ch_above_short_level,
  input wire logic [3:0] ch_powergood_reached,
  input wire logic [3:0] ch_current_limit,
  input wire logic overheat_shutdown_in,
  input wire logic overheat_warning_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [7:0] pair_low_flags,
  output logic [7:0] pair_high_flags,
  output logic [7:0] top_event_flags
);
  // Synchroniser stages, one pair per comparator group; only the second
  // stage of each pair is ever read by logic
  logic [3:0] en_meta;
  logic [3:0] next_en_meta;
  logic [3:0] en_s;
  logic [3:0] next_en_s;
  logic [3:0] above_meta;
  logic [3:0] next_above_meta;
  logic [3:0] above_s;
  logic [3:0] next_above_s;
  logic [3:0] pg_meta;
  logic [3:0] next_pg_meta;
  logic [3:0] pg_s;
  logic [3:0] next_pg_s;
  logic [3:0] ilim_meta;
  logic [3:0] next_ilim_meta;
  logic [3:0] ilim_s;
  logic [3:0] next_ilim_s;
  logic shutdown_meta;
  logic next_shutdown_meta;
  logic overheat_shutdown_live;
  logic next_overheat_shutdown_live;
  logic warning_meta;
  logic next_warning_meta;
  logic overheat_warning_live;
  logic next_overheat_warning_live;
  // Per-channel flag state lives in the channel instances
  logic [2:0] ch_flags [rfef_pkg::NUM_CH];
  logic [2:0] ch_clear [rfef_pkg::NUM_CH];
  // Host write decode, one strobe per writable register
  logic wr_pair_low;
  logic wr_pair_high;
  logic wr_top_event;
  logic [7:0] thermal_live_status;
  logic [1:0] thermal_events;
  logic [1:0] next_thermal_events;
  logic [7:0] next_rdata;
  logic [7:0] next_top;
  logic [7:0] next_low;
  logic [7:0] next_high;

  // First stage samples the pins, second stage samples the first
  always_comb begin
    next_en_meta = ch_enabled;
    next_above_meta = ch_above_short_level;
    next_pg_meta = ch_powergood_reached;
    next_ilim_meta = ch_current_limit;
    next_shutdown_meta = overheat_shutdown_in;
    next_warning_meta = overheat_warning_in;
    next_en_s = en_meta;
    next_above_s = above_meta;
    next_pg_s = pg_meta;
    next_ilim_s = ilim_meta;
    next_overheat_shutdown_live = shutdown_meta;
    next_overheat_warning_live = warning_meta;
  end

  // Cleared in reset so no channel looks enabled before the pins settle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      en_meta <= '0;
      above_meta <= '0;
      pg_meta <= '0;
      ilim_meta <= '0;
      shutdown_meta <= 1'b0;
      warning_meta <= 1'b0;
      en_s <= '0;
      above_s <= '0;
      pg_s <= '0;
      ilim_s <= '0;
      overheat_shutdown_live <= 1'b0;
      overheat_warning_live <= 1'b0;
    end else begin
      en_meta <= next_en_meta;
      above_meta <= next_above_meta;
      pg_meta <= next_pg_meta;
      ilim_meta <= next_ilim_meta;
      shutdown_meta <= next_shutdown_meta;
      warning_meta <= next_warning_meta;
      en_s <= next_en_s;
      above_s <= next_above_s;
      pg_s <= next_pg_s;
      ilim_s <= next_ilim_s;
      overheat_shutdown_live <= next_overheat_shutdown_live;
      overheat_warning_live <= next_overheat_warning_live;
    end
  end

  // Write strobes; the thermal status address gets none at all
  always_comb begin
    wr_pair_low = reg_wr && (reg_addr == rfef_pkg::ADDR_PAIR_LOW);
    wr_pair_high = reg_wr && (reg_addr == rfef_pkg::ADDR_PAIR_HIGH);
    wr_top_event = reg_wr && (reg_addr == rfef_pkg::ADDR_TOP_EVENT);
  end

  // Per-channel flags; even channels in low nibble, odd in high
  for (genvar c = 0; c < rfef_pkg::NUM_CH; c++) begin : g_ch
    localparam int LSB = (c % 2) * rfef_pkg::NIBBLE;
    // First pair answers at the low event address, second at the high one
    logic wr_this;
    assign wr_this = (c < rfef_pkg::NUM_CH / 2) ? wr_pair_low : wr_pair_high;
    assign ch_clear[c] = wr_this ? reg_wdata[LSB +: 3] : 3'h0;
    rfef_channel #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_ch (
      .core_clk(core_clk),
      .nrst(nrst),
      .enabled(en_s[c]),
      .above_short_level(above_s[c]),
      .powergood_reached(pg_s[c]),
      .current_limit(ilim_s[c]),
      .clear(ch_clear[c]),
      .flags(ch_flags[c])
    );
  end

  // Live thermal status, reserved bits zero
  always_comb begin
    thermal_live_status = rfef_pkg::RESET_BYTE;
    thermal_live_status[rfef_pkg::BIT_SHUTDOWN] = overheat_shutdown_live;
    thermal_live_status[rfef_pkg::BIT_WARNING] = overheat_warning_live;
  end

  // Latched thermal events fed from live status; live bits never touched
  always_comb begin
    logic [1:0] clr;
    clr = '0;
    if (wr_top_event) begin
      clr = {reg_wdata[rfef_pkg::BIT_SHUTDOWN], reg_wdata[rfef_pkg::BIT_WARNING]};
    end
    next_thermal_events = (thermal_events & ~clr) |
      {thermal_live_status[rfef_pkg::BIT_SHUTDOWN],
       thermal_live_status[rfef_pkg::BIT_WARNING]};
  end

  // Register images; pair images keep reserved bits 7 and 3 zero
  always_comb begin
    next_low = {1'b0, ch_flags[1], 1'b0, ch_flags[0]};
    next_high = {1'b0, ch_flags[3], 1'b0, ch_flags[2]};
    next_top = rfef_pkg::RESET_BYTE;
    for (int c = 0; c < rfef_pkg::NUM_CH; c++) begin
      next_top[rfef_pkg::BIT_SUMMARY0 + c] = |ch_flags[c];
    end
    next_top[rfef_pkg::BIT_SHUTDOWN] = thermal_events[1];
    next_top[rfef_pkg::BIT_WARNING] = thermal_events[0];
  end

  // Read mux; thermal status has no write path at all
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        rfef_pkg::ADDR_TOP_EVENT: next_rdata = top_event_flags;
        rfef_pkg::ADDR_PAIR_LOW: next_rdata = pair_low_flags;
        rfef_pkg::ADDR_PAIR_HIGH: next_rdata = pair_high_flags;
        rfef_pkg::ADDR_THERMAL: next_rdata = thermal_live_status;
        default: next_rdata = rfef_pkg::RESET_BYTE;
      endcase
    end
  end

  // Thermal event latches
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      thermal_events <= '0;
    end else begin
      thermal_events <= next_thermal_events;
    end
  end

  // Read data holds its last value between reads
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= rfef_pkg::RESET_BYTE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Images trail the flags by a cycle; a read right after a clear
  // still shows the old image, so hosts leave one idle cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pair_low_flags <= rfef_pkg::RESET_BYTE;
      pair_high_flags <= rfef_pkg::RESET_BYTE;
      top_event_flags <= rfef_pkg::RESET_BYTE;
    end else begin
      pair_low_flags <= next_low;
      pair_high_flags <= next_high;
      top_event_flags <= next_top;
    end
  end
endmodule
`default_nettype wire

// ==== verif/rfef_asserts.sv ====
// Checker: port-level assertions for the event flag block
`default_nettype none
module rfef_asserts #(
  parameter int TIMEOUT_CYC = 20
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] ch_enabled,
  input wire logic [3:0] ch_above_short_level,
  input wire logic [3:0] ch_powergood_reached,
  input wire logic [3:0] ch_current_limit,
  input wire logic overheat_shutdown_in,
  input wire logic overheat_warning_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pair_low_flags,
  input wire logic [7:0] pair_high_flags,
  input wire logic [7:0] top_event_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain; nothing is judged while reset is held
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Cycles that channel 2 has been enabled with its output still low
  int unsigned stall_cyc;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stall_cyc <= 0;
    end else if (ch_enabled[2] && !ch_above_short_level[2]) begin
      stall_cyc <= stall_cyc + 1;
    end else begin
      stall_cyc <= 0;
    end
  end
  // Margin of four: two sync stages, the flag and its image
  startup_short_a: assert property (stall_cyc >= TIMEOUT_CYC + 4 |-> pair_high_flags[1])
    else $error("start-up timeout flag missed");
  ilim_set_a: assert property (ch_current_limit[0] [*4] |=> pair_low_flags[0])
    else $error("current limit flag missed");
  pg_set_a: assert property (ch_powergood_reached[1] [*4] |=> pair_low_flags[6])
    else $error("power good flag missed");
  rsvd_zero_a: assert property (((pair_low_flags | pair_high_flags) & 8'h88) == 8'h00)
    else $error("reserved flag bit set");
  w1c_only_a: assert property ($fell(pair_low_flags[0]) |->
    $past(reg_wr && reg_addr == 8'h19 && reg_wdata[0], 2)) else $error("flag lost");
  summary_a: assert property (top_event_flags[5] == (|pair_low_flags[6:4]))
    else $error("summary wrong");
  sd_live_a: assert property ((overheat_shutdown_in [*4] ##0
    (reg_rd && reg_addr == 8'h1B)) |=> reg_rdata[3]) else $error("shutdown not live");
  stat_zero_a: assert property (reg_rd && reg_addr == 8'h1B |=>
    (reg_rdata & 8'hF3) == 8'h00) else $error("status reserved set");
  unmapped_a: assert property (reg_rd && (reg_addr < 8'h18 || reg_addr > 8'h1B) |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  cover property (reg_rd && reg_addr == 8'h1B);
  cover property ($fell(pair_low_flags[0]));
  cover property ($rose(pair_high_flags[1]));
  cover property (stall_cyc == TIMEOUT_CYC + 4);
endmodule
bind rfef_top rfef_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_asserts (
  .core_clk(core_clk),
  .nrst(nrst),
  .ch_enabled(ch_enabled),
  .ch_above_short_level(ch_above_short_level),
  .ch_powergood_reached(ch_powergood_reached),
  .ch_current_limit(ch_current_limit),
  .overheat_shutdown_in(overheat_shutdown_in),
  .overheat_warning_in(overheat_warning_in),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .pair_low_flags(pair_low_flags),
  .pair_high_flags(pair_high_flags),
  .top_event_flags(top_event_flags)
);
`default_nettype wire

// ==== verif/rfef_conv_model.sv ====
// Partner model: four converter outputs that ramp up and decay
`default_nettype none
module rfef_conv_model (
  input wire logic core_clk,
  input wire logic [3:0] ch_enabled,
  input wire logic [3:0] stuck,
  output logic [3:0] ch_above_short_level,
  output logic [3:0] ch_powergood_reached
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lvl [4] = '{default: 4'h0};
  // Slow decay so a disable never looks like a short to the block
  always @(negedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (ch_enabled[i] && !stuck[i] && lvl[i] < 4'h8) lvl[i] <= lvl[i] + 4'h1;
      else if ((!ch_enabled[i] || stuck[i]) && lvl[i] > 4'h0) lvl[i] <= lvl[i] - 4'h1;
    end
  end
  // Threshold crossings as seen by the comparators
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ch_above_short_level[i] = lvl[i] >= 4'h5;
      ch_powergood_reached[i] = lvl[i] == 4'h8;
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_regulator_fault_event_flags.sv ====
// Testbench: event injection, register reads and flag clearing
`default_nettype none
module tb_regulator_fault_event_flags;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] ch_enabled = 4'h0, ch_current_limit = 4'h0, stuck = 4'h0, r;
  logic overheat_shutdown_in = 1'b0, overheat_warning_in = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, e19, e1a, m;
  logic [7:0] pair_low_flags, pair_high_flags, top_event_flags;
  logic [3:0] ch_above_short_level, ch_powergood_reached;
  logic [7:0] exp_q [$];
  int mismatches = 0, n_tests = 0;
  rfef_top #(.TIMEOUT_CYC(20)) DUT (
    .core_clk(core_clk),
    .nrst(nrst),
    .ch_enabled(ch_enabled),
    .ch_above_short_level(ch_above_short_level),
    .ch_powergood_reached(ch_powergood_reached),
    .ch_current_limit(ch_current_limit),
    .overheat_shutdown_in(overheat_shutdown_in),
    .overheat_warning_in(overheat_warning_in),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .pair_low_flags(pair_low_flags),
    .pair_high_flags(pair_high_flags),
    .top_event_flags(top_event_flags)
  );
  rfef_conv_model u_model (
    .core_clk(core_clk),
    .ch_enabled(ch_enabled),
    .stuck(stuck),
    .ch_above_short_level(ch_above_short_level),
    .ch_powergood_reached(ch_powergood_reached)
  );
  initial forever #20 core_clk = ~core_clk;
  task automatic check(input string name, input [7:0] seen, input [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      mismatches++;
    end
  endtask
  // Host access: one-cycle strobe, reads leave their expectation in the queue
  task automatic acc(input bit w, input [7:0] a, input [7:0] d);
    @(negedge core_clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    if (!w) exp_q.push_back(d);
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic print_verdict();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Monitor pairs each read answer with the oldest expectation
  always @(posedge core_clk) rd_d <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_d && exp_q.size() == 0) begin
      $display("[FAIL] reg_rdata expected nothing seen %h", reg_rdata);
      mismatches++;
    end else if (rd_d) check("reg_rdata", reg_rdata, exp_q.pop_front());
  end
  initial begin
    r = 4'($urandom(32'h0F41B910));
    m = 8'($urandom());
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    for (int a = 8'h17; a < 8'h1D; a++) acc(1'b0, 8'(a), 8'h00);
    // Channel 2 never rises, so only its start-up timer can flag it
    stuck = 4'h4;
    ch_enabled = 4'hF;
    repeat (40) @(negedge core_clk);
    ch_current_limit = r;
    repeat (6) @(negedge core_clk);
    ch_current_limit = 4'h0;
    stuck = 4'h6;
    repeat (12) @(negedge core_clk);
    e19 = {3'b011, r[1], 3'b010, r[0]};
    e1a = {3'b010, r[3], 3'b001, r[2]};
    acc(1'b0, 8'h19, e19);
    acc(1'b0, 8'h1A, e1a);
    acc(1'b0, 8'h18, 8'hF0);
    ch_enabled = 4'h0;
    repeat (8) @(negedge core_clk);
    acc(1'b1, 8'h19, 8'h00);
    acc(1'b0, 8'h19, e19);
    acc(1'b1, 8'h19, m);
    acc(1'b0, 8'h19, e19 & ~m);
    acc(1'b1, 8'h19, 8'hFF);
    acc(1'b1, 8'h1A, 8'hFF);
    acc(1'b0, 8'h18, 8'h00);
    // Clears against a live event must lose
    ch_current_limit = 4'h9;
    repeat (5) @(negedge core_clk);
    acc(1'b1, 8'h19, 8'hFF);
    acc(1'b1, 8'h1A, 8'hFF);
    acc(1'b0, 8'h19, 8'h01);
    acc(1'b0, 8'h1A, 8'h10);
    ch_current_limit = 4'h0;
    for (int i = 0; i < 4; i++) begin
      {overheat_shutdown_in, overheat_warning_in} = 2'(i);
      repeat (4) @(negedge core_clk);
      acc(1'b0, 8'h1B, {4'h0, 2'(i), 2'b00});
    end
    {overheat_shutdown_in, overheat_warning_in} = 2'b00;
    repeat (4) @(negedge core_clk);
    acc(1'b1, 8'h1B, 8'hFF);
    acc(1'b0, 8'h1B, 8'h00);
    acc(1'b0, 8'h18, 8'h9C);
    acc(1'b1, 8'h18, 8'h0C);
    acc(1'b0, 8'h18, 8'h90);
    repeat (3) @(negedge core_clk);
    print_verdict();
  end
  // Watchdog sized well beyond the roughly 155 cycles the tests take
  initial begin
    repeat (3000) @(posedge core_clk);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
